// >>> bench/tr_host_model.sv
// tr_host_model: host controller model issuing register reads and writes
module tr_host_model (
    input  wire logic       mclk_in,    // system clock
    output logic      [7:0] addr_out,   // register address
    output logic            wr_out,     // write strobe
    output logic      [7:0] wdata_out,  // write data
    output logic            rd_out,     // read strobe
    input  wire logic [7:0] rdata_in    // read data from device
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        addr_out  = 8'h00;
        wr_out    = 1'b0;
        wdata_out = 8'h00;
        rd_out    = 1'b0;
    end

    // one-cycle write strobe; address and data go to junk after so stale values are never trusted
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge mclk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask : wr_reg

    // one-cycle read strobe, data taken one cycle after the device sampled it
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge mclk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(posedge mclk_in);
        d = rdata_in;
    endtask : rd_reg

    // high byte first, word formed by concatenation
    task automatic rd_word(output logic [15:0] w);
        logic [7:0] hi;
        logic [7:0] lo;
        rd_reg(8'h21, hi);
        rd_reg(8'h20, lo);
        w = {hi, lo};
    endtask : rd_word
endmodule : tr_host_model

// >>> bench/tr_temp_readout_tb.sv
// tr_temp_readout_tb: self-checking bench for the temperature readout block
module tr_temp_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tr_pkg::*;

    localparam int C12 = 40;  // shortened periods keep the run small
    localparam int C26 = 20;
    localparam int C52 = 10;

    logic        mclk_in;      // clock
    logic        rst_n_in;     // reset, active low
    logic [7:0]  addr;         // register address
    logic        wr;           // write strobe
    logic [7:0]  wdata;        // write data
    logic        rd;           // read strobe
    logic [7:0]  rdata;        // read data
    logic [15:0] temp_raw;     // sensed temperature
    logic        pin;          // second interrupt pin
    int          cyc = 0;      // free-running cycle count
    int          n_mismatch;   // mismatches
    int          n_compared;   // comparisons
    logic [7:0]  b;            // read byte
    logic [15:0] w;            // read word
    int          t0;           // rise stamps
    int          t1;
    // rate table: accel ctrl, gyro ctrl, expected period
    logic [7:0]  acc_v[6] = '{8'h11, 8'h21, 8'h10, 8'h31, 8'h00, 8'h11};
    logic [7:0]  gyr_v[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h10};
    int          per_v[6] = '{C12, C26, C52, C52, C52, C52};
    // temperature table: absolute input, expected output word
    logic [15:0] raw_v[4] = '{16'h0000, 16'h1900, 16'h3200, 16'h1A80};
    logic [15:0] out_v[4] = '{16'hE700, 16'h0000, 16'h1900, 16'h0180};

    tr_temp_readout #(.CYC_12P5(C12), .CYC_26(C26), .CYC_52(C52)) tr_temp_readout_inst (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .temp_raw_in(temp_raw),
        .second_interrupt_pin_out(pin));

    tr_host_model tr_host_model_inst (
        .mclk_in(mclk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
        .rd_out(rd), .rdata_in(rdata));

    // 25 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // cycle stamp for period measurement
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
    end

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_count(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_count

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // bounded wait for the pin to read high; a hang ends the run
    task automatic wait_rise(output int stamp);
        int k;
        for (k = 0; k < 300 && pin !== 1'b1; k++) begin
            @(posedge mclk_in);
        end
        stamp = cyc;
        if (pin !== 1'b1) begin
            n_mismatch++;
            $display("BAD pin rise expected 1 seen %b", pin);
            wrap_up();
        end
    endtask : wait_rise

    initial begin
        rst_n_in = 1'b0;
        temp_raw = 16'h1900;
        n_mismatch = 0;
        n_compared = 0;
        repeat (20) @(posedge mclk_in);
        chk_byte("pin in reset", 8'h00, {7'h00, pin});
        rst_n_in <= 1'b1;
        // reset values, read-only and unmapped places
        tr_host_model_inst.wr_reg(8'h20, 8'hFF);
        tr_host_model_inst.rd_reg(8'h20, b);
        chk_byte("temp low", 8'h00, b);
        tr_host_model_inst.rd_reg(8'h21, b);
        chk_byte("temp high", 8'h00, b);
        tr_host_model_inst.rd_reg(8'h55, b);
        chk_byte("unmapped", 8'h00, b);
        repeat (100) @(posedge mclk_in);
        tr_host_model_inst.rd_reg(TR_ADDR_STATUS, b);
        chk_byte("status while off", 8'h00, b);
        $display("test reset and off done");
        // sample period for six power and rate combinations
        tr_host_model_inst.wr_reg(TR_ADDR_ROUTE, 8'h08);
        tr_host_model_inst.rd_reg(TR_ADDR_ROUTE, b);
        chk_byte("route readback", 8'h08, b);
        for (int i = 0; i < 6; i++) begin
            tr_host_model_inst.wr_reg(TR_ADDR_ACCEL, acc_v[i]);
            tr_host_model_inst.wr_reg(TR_ADDR_GYRO, gyr_v[i]);
            tr_host_model_inst.rd_reg(TR_ADDR_ACCEL, b);
            chk_byte("accel readback", acc_v[i], b);
            tr_host_model_inst.rd_reg(TR_ADDR_GYRO, b);
            chk_byte("gyro readback", gyr_v[i], b);
            repeat (50) @(posedge mclk_in);
            tr_host_model_inst.rd_reg(8'h20, b);
            wait_rise(t0);
            tr_host_model_inst.rd_reg(8'h21, b);
            tr_host_model_inst.rd_reg(TR_ADDR_STATUS, b);
            chk_byte("status after read", 8'h00, b);
            wait_rise(t1);
            chk_count("sample period", per_v[i], t1 - t0);
        end
        $display("test rates done");
        // output word scaling and zero point
        for (int i = 0; i < 4; i++) begin
            temp_raw <= raw_v[i];
            wait_rise(t0);
            tr_host_model_inst.rd_reg(8'h20, b);
            wait_rise(t1);
            tr_host_model_inst.rd_word(w);
            chk_byte("word high", out_v[i][15:8], w[15:8]);
            chk_byte("word low", out_v[i][7:0], w[7:0]);
        end
        $display("test values done");
        // routing off: flag still set, pin quiet
        tr_host_model_inst.wr_reg(TR_ADDR_ROUTE, 8'h00);
        repeat (30) @(posedge mclk_in);
        chk_byte("pin unrouted", 8'h00, {7'h00, pin});
        tr_host_model_inst.rd_reg(TR_ADDR_STATUS, b);
        chk_byte("status flag", 8'h04, b);
        // both sensors down again: no further samples
        tr_host_model_inst.wr_reg(TR_ADDR_ACCEL, 8'h00);
        tr_host_model_inst.wr_reg(TR_ADDR_GYRO, 8'h00);
        repeat (5) @(posedge mclk_in);
        tr_host_model_inst.rd_reg(8'h20, b);
        repeat (100) @(posedge mclk_in);
        tr_host_model_inst.rd_reg(TR_ADDR_STATUS, b);
        chk_byte("status powered down", 8'h00, b);
        $display("test route and shutdown done");
        wrap_up();
    end
endmodule : tr_temp_readout_tb

// >>> verilog/tr_pkg.sv
// tr_pkg: register map, field layout, rate codes and timing constants of the temperature readout
package tr_pkg;
    // clock and sample rates, rates held in units of 0.01 Hz
    localparam longint TR_CLK_HZ       = 64'd25000000;  // system clock rate
    localparam longint TR_RATE_12P5_CHZ = 64'd1250;     // 12.5 Hz
    localparam longint TR_RATE_26_CHZ   = 64'd2600;     // 26 Hz
    localparam longint TR_RATE_52_CHZ   = 64'd5200;     // 52 Hz, top temperature rate
    // cycles per sample period, rounded down
    localparam int TR_CYC_12P5 = int'((TR_CLK_HZ * 64'd100) / TR_RATE_12P5_CHZ);
    localparam int TR_CYC_26   = int'((TR_CLK_HZ * 64'd100) / TR_RATE_26_CHZ);
    localparam int TR_CYC_52   = int'((TR_CLK_HZ * 64'd100) / TR_RATE_52_CHZ);
    localparam int TR_CNT_W    = 22;                    // wide enough for the slowest period

    // register byte offsets
    localparam logic [7:0] TR_ADDR_ROUTE  = 8'h0D;      // pin_two_route_control
    localparam logic [7:0] TR_ADDR_ACCEL  = 8'h10;      // accelerometer rate/mode control
    localparam logic [7:0] TR_ADDR_GYRO   = 8'h11;      // gyroscope rate control
    localparam logic [7:0] TR_ADDR_STATUS = 8'h1E;      // status
    localparam logic [7:0] TR_ADDR_TLOW   = 8'h20;      // temp_out_low
    localparam logic [7:0] TR_ADDR_THIGH  = 8'h21;      // temp_out_high

    // field positions
    localparam int TR_ODR_LSB       = 4;                // rate code in bits 7:4
    localparam int TR_ODR_W         = 4;                // rate code width
    localparam int TR_LP_BIT        = 0;                // accelerometer low-power bit
    localparam int TR_ROUTE_TEMP_BIT = 3;               // temp_ready_route_pin_two
    localparam int TR_STAT_TEMP_BIT = 2;                // temp_sample_avail_flag

    // rate codes of the sensor control registers
    localparam logic [3:0] TR_ODR_OFF  = 4'h0;          // power-down
    localparam logic [3:0] TR_ODR_12P5 = 4'h1;          // 12.5 Hz
    localparam logic [3:0] TR_ODR_26   = 4'h2;          // 26 Hz

    // reset values
    localparam logic [7:0]  TR_RST_CTRL = 8'h00;        // both sensors powered down
    localparam logic [15:0] TR_RST_TEMP = 16'h0000;     // output word before first sample

    // zero point: 25 degC at 256 LSB per degC
    localparam logic signed [15:0] TR_ZERO_OFFSET = 16'sh1900;

    // temperature sample rate, gray coded along off -> slow -> fast
    typedef enum logic [1:0] {
        TR_RATE_OFF  = 2'b00,
        TR_RATE_12P5 = 2'b01,
        TR_RATE_26   = 2'b11,
        TR_RATE_52   = 2'b10
    } tr_rate_t;
endpackage : tr_pkg

// >>> verilog/tr_rate_gen.sv
// tr_rate_gen: period counter that paces temperature samples at the selected rate
module tr_rate_gen
    import tr_pkg::*;
#(
    parameter int CYC_12P5 = TR_CYC_12P5,  // clocks per 12.5 Hz period
    parameter int CYC_26   = TR_CYC_26,    // clocks per 26 Hz period
    parameter int CYC_52   = TR_CYC_52     // clocks per 52 Hz period
) (
    input  wire logic mclk_in,   // system clock
    input  wire logic rst_n_in,  // async reset, active low
    tr_rate_if.gen    rif        // rate in, tick out
);
    logic [TR_CNT_W-1:0] cnt_q;   // cycles elapsed in current period
    logic [TR_CNT_W-1:0] cnt_d;
    logic [TR_CNT_W-1:0] last_w;  // terminal count of current rate
    tr_rate_t            rate_q;  // rate seen last cycle, to restart on change
    logic                tick_q;
    logic                tick_d;

    // pick the terminal count; a rate change restarts the period so no short sample slips out
    always_comb begin
        case (rif.rate)
            TR_RATE_12P5: last_w = TR_CNT_W'(CYC_12P5 - 1);
            TR_RATE_26:   last_w = TR_CNT_W'(CYC_26 - 1);
            TR_RATE_52:   last_w = TR_CNT_W'(CYC_52 - 1);
            default:      last_w = '0;
        endcase
        tick_d = 1'b0;
        if (rif.rate == TR_RATE_OFF || rif.rate != rate_q) begin
            cnt_d = '0;                                  // sensor off: no samples
        end else if (cnt_q >= last_w) begin
            cnt_d  = '0;
            tick_d = 1'b1;                               // one sample per period
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // register counter state
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q  <= '0;
            rate_q <= TR_RATE_OFF;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            rate_q <= rif.rate;
            tick_q <= tick_d;
        end
    end

    assign rif.tick = tick_q;

    chk_off_no_tick: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (rif.rate == TR_RATE_OFF) [*2] |-> !rif.tick)
        else $error("tick while temperature sensor off");
endmodule : tr_rate_gen

// >>> verilog/tr_rate_if.sv
// tr_rate_if: rate selection and sample tick between the control logic and the tick generator
interface tr_rate_if;
    import tr_pkg::*;
    tr_rate_t rate;   // selected temperature rate, off when sensor unpowered
    logic     tick;   // one-cycle pulse per temperature sample

    modport ctrl (output rate, input tick);
    modport gen  (input rate, output tick);
endinterface : tr_rate_if

// >>> verilog/tr_temp_readout.sv
// tr_temp_readout: temperature sensor power, rate, data-ready flag and output registers
// Function
// - sensor off when both sensors powered down
// - gyro off, low-power slow accel: accel rate
// - gyro off, other accel setting: 52 Hz
// - gyro active: always 52 Hz
// - new sample sets data-available status flag
// - routing bit drives flag onto pin two
// - sixteen-bit two's complement, 256 LSB per degree
// - output zero at 25 degrees Celsius
// - high byte at 21h, low at 20h
module tr_temp_readout
    import tr_pkg::*;
#(
    parameter int CYC_12P5 = TR_CYC_12P5,  // clocks per 12.5 Hz period
    parameter int CYC_26   = TR_CYC_26,    // clocks per 26 Hz period
    parameter int CYC_52   = TR_CYC_52     // clocks per 52 Hz period
) (
    input  wire logic        mclk_in,              // system clock, 25 MHz
    input  wire logic        rst_n_in,             // async reset, active low
    input  wire logic [7:0]  reg_addr_in,          // register byte address
    input  wire logic        reg_wr_in,            // write strobe, one cycle
    input  wire logic [7:0]  reg_wdata_in,         // write data
    input  wire logic        reg_rd_in,            // read strobe, one cycle
    output logic      [7:0]  reg_rdata_out,        // read data, valid cycle after strobe
    input  wire logic [15:0] temp_raw_in,          // sensed temperature, degC x 256, async
    output logic             second_interrupt_pin_out  // second interrupt pin
);
    tr_rate_if rif ();                             // link to tick generator

    // control registers written by the host
    logic [7:0]  accel_q, accel_d;                 // accelerometer rate/mode
    logic [7:0]  gyro_q,  gyro_d;                  // gyroscope rate
    logic [7:0]  route_q, route_d;                 // pin_two_route_control
    // sample state
    logic [15:0] temp_q,  temp_d;                  // output word
    logic        flag_q,  flag_d;                  // temp_sample_avail_flag
    logic [7:0]  rdata_q, rdata_d;                 // read data latch
    tr_rate_t    rate_q,  rate_d;                  // decoded temperature rate
    // raw input synchroniser: first stage is read only by the second
    logic [15:0] raw_s1_q, raw_s2_q;

    logic [3:0]  aodr_w, godr_w;                   // rate code fields
    logic        alp_w;                            // accel low-power mode
    logic        rd_out_w;                         // read of an output register

    assign aodr_w   = accel_q[TR_ODR_LSB +: TR_ODR_W];
    assign godr_w   = gyro_q[TR_ODR_LSB +: TR_ODR_W];
    assign alp_w    = accel_q[TR_LP_BIT];
    assign rd_out_w = reg_rd_in && (reg_addr_in == TR_ADDR_TLOW || reg_addr_in == TR_ADDR_THIGH);

    // double-flop the raw word; it only changes slowly against the sample period
    // limitation: no handshake on this word, so it must hold still a few cycles before a sample
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            raw_s1_q <= '0;
            raw_s2_q <= '0;
        end else begin
            raw_s1_q <= temp_raw_in;
            raw_s2_q <= raw_s1_q;
        end
    end

    // decode the temperature rate from the two sensors' settings
    // only 12.5 and 26 Hz sit below 52 Hz; every faster accel code clamps to 52 Hz
    always_comb begin
        if (aodr_w == TR_ODR_OFF && godr_w == TR_ODR_OFF) begin
            rate_d = TR_RATE_OFF;                        // both down: sensor off
        end else if (godr_w != TR_ODR_OFF) begin
            rate_d = TR_RATE_52;                         // gyro active
        end else if (alp_w && aodr_w == TR_ODR_12P5) begin
            rate_d = TR_RATE_12P5;                       // follow slow accel rate
        end else if (alp_w && aodr_w == TR_ODR_26) begin
            rate_d = TR_RATE_26;                         // follow slow accel rate
        end else begin
            rate_d = TR_RATE_52;                         // any other accel setting
        end
    end

    assign rif.rate = rate_q;

    // host writes; unmapped and read-only addresses ignore writes
    always_comb begin
        accel_d = accel_q;
        gyro_d  = gyro_q;
        route_d = route_q;
        if (reg_wr_in) begin
            case (reg_addr_in)
                TR_ADDR_ACCEL: accel_d = reg_wdata_in;
                TR_ADDR_GYRO:  gyro_d  = reg_wdata_in;
                TR_ADDR_ROUTE: route_d = reg_wdata_in;
                default:       ;                         // no writable register here
            endcase
        end
    end

    // sample capture and flag; a new sample in the read cycle keeps the flag set
    // the subtraction wraps at 16 bits, which a two's-complement reader expects
    always_comb begin
        temp_d = temp_q;
        flag_d = flag_q;
        if (rd_out_w) begin
            flag_d = 1'b0;                               // host consumed the sample
        end
        if (rif.tick) begin
            temp_d = raw_s2_q - TR_ZERO_OFFSET;          // 25 degC reads as zero
            flag_d = 1'b1;                               // set wins over clear
        end
    end

    // read mux; unmapped addresses read zero
    // no snapshot of the word: read both bytes soon after the flag rises, before the next sample
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_in) begin
            case (reg_addr_in)
                TR_ADDR_ACCEL:  rdata_d = accel_q;
                TR_ADDR_GYRO:   rdata_d = gyro_q;
                TR_ADDR_ROUTE:  rdata_d = route_q;
                TR_ADDR_STATUS: rdata_d = 8'(flag_q) << TR_STAT_TEMP_BIT;
                TR_ADDR_TLOW:   rdata_d = temp_q[7:0];   // low byte
                TR_ADDR_THIGH:  rdata_d = temp_q[15:8];  // high byte
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    // register all state
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            accel_q <= TR_RST_CTRL;
            gyro_q  <= TR_RST_CTRL;
            route_q <= TR_RST_CTRL;
            temp_q  <= TR_RST_TEMP;
            flag_q  <= 1'b0;
            rdata_q <= 8'h00;
            rate_q  <= TR_RATE_OFF;
        end else begin
            accel_q <= accel_d;
            gyro_q  <= gyro_d;
            route_q <= route_d;
            temp_q  <= temp_d;
            flag_q  <= flag_d;
            rdata_q <= rdata_d;
            rate_q  <= rate_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    // pin shows the flag only while routed; both terms are flops so the pin is glitch free
    assign second_interrupt_pin_out = route_q[TR_ROUTE_TEMP_BIT] & flag_q;

    // tick generator; a rate change restarts its period
    tr_rate_gen #(
        .CYC_12P5 (CYC_12P5),
        .CYC_26   (CYC_26),
        .CYC_52   (CYC_52)
    ) u_rate (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .rif      (rif)
    );

    // rate decode: every power and rate setting maps to one temperature rate
    chk_both_down_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (aodr_w == TR_ODR_OFF && godr_w == TR_ODR_OFF) |=> (rate_q == TR_RATE_OFF))
        else $error("sensor not off with both sensors down");
    chk_slow_accel_rate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (godr_w == TR_ODR_OFF && alp_w && aodr_w == TR_ODR_26) |=> (rate_q == TR_RATE_26))
        else $error("temperature rate not following slow accel rate");
    chk_slow_12p5_rate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (godr_w == TR_ODR_OFF && alp_w && aodr_w == TR_ODR_12P5) |=> (rate_q == TR_RATE_12P5))
        else $error("temperature rate not following 12.5 Hz accel rate");
    chk_fast_lp_rate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (godr_w == TR_ODR_OFF && alp_w && aodr_w > TR_ODR_26) |=> (rate_q == TR_RATE_52))
        else $error("temperature rate not 52 Hz for fast low-power accel");
    chk_other_accel_rate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (godr_w == TR_ODR_OFF && !alp_w && aodr_w != TR_ODR_OFF) |=> (rate_q == TR_RATE_52))
        else $error("temperature rate not 52 Hz for normal accel");
    chk_gyro_rate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (godr_w != TR_ODR_OFF) |=> (rate_q == TR_RATE_52))
        else $error("temperature rate not 52 Hz with gyro active");
    chk_off_word_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (rif.rate == TR_RATE_OFF && !rif.tick) |=> $stable(temp_q))
        else $error("output word changed while sensor off");

    // flag, pin and output word
    chk_flag_on_tick: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rif.tick |=> flag_q && $changed(temp_q) || flag_q)
        else $error("flag not set by new sample");
    chk_pin_route: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rif.tick |=> (second_interrupt_pin_out == route_q[TR_ROUTE_TEMP_BIT]))
        else $error("pin two not following routed flag");
    chk_pin_unrouted: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !route_q[TR_ROUTE_TEMP_BIT] |-> !second_interrupt_pin_out)
        else $error("pin two active while not routed");
    chk_word_scale: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rif.tick |=> (temp_q == $past(raw_s2_q) - TR_ZERO_OFFSET))
        else $error("output word not scaled from raw value");
    chk_zero_point: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rif.tick && raw_s2_q == TR_ZERO_OFFSET |=> (temp_q == 16'h0000))
        else $error("25 degC does not read as zero");

    // read path: bytes and status come out one cycle after the strobe
    chk_high_byte: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == TR_ADDR_THIGH |=> (reg_rdata_out == $past(temp_q[15:8])))
        else $error("high byte not at its address");
    chk_low_byte: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == TR_ADDR_TLOW |=> (reg_rdata_out == $past(temp_q[7:0])))
        else $error("low byte not at its address");
    chk_status_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == TR_ADDR_STATUS |=> (reg_rdata_out[TR_STAT_TEMP_BIT] == $past(flag_q)))
        else $error("status bit not showing the flag");
    chk_flag_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!rd_out_w && !rif.tick) |=> (flag_q == $past(flag_q)))
        else $error("flag changed without sample or read");
    chk_read_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rd_out_w && !rif.tick |=> !flag_q)
        else $error("flag not cleared by output read");
endmodule : tr_temp_readout
